/* File: caf_filter.sv */
// acceptance filter: scans the filter table in priority order for one frame
// assumes frame_ready_in pulses once header and first three bytes are held
`timescale 1ns/1ps
module caf_filter
   import caf_pkg::*;
#(
   parameter int NUM_FILTERS = CAF_NUM_FILTERS,
   parameter int NUM_FIFOS = CAF_NUM_FIFOS
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // filter table write
   input wire logic cfg_wr_in,
   input wire logic [CAF_IDX_W-1:0] cfg_idx_in,
   input wire logic [CAF_OBJ_W-1:0] cfg_filter_object_in,
   input wire logic [CAF_OBJ_W-1:0] cfg_mask_object_in,
   input wire logic [CAF_IDX_W-1:0] cfg_filter_buffer_pointer_in,
   input wire logic cfg_filter_enable_in,
   // global settings
   input wire logic [4:0] data_compare_count_in,
   input wire logic twelve_bit_id_enable_in,
   // fifo state
   input wire logic [NUM_FIFOS-1:0] fifo_is_transmit_in,
   input wire logic [NUM_FIFOS-1:0] remote_response_enable_in,
   input wire logic [NUM_FIFOS-1:0] fifo_full_in,
   input wire logic [NUM_FIFOS-1:0] fifo_empty_in,
   // frame from the rx assembly buffer
   input wire logic frame_ready_in,
   input wire logic rx_error_in,
   input wire logic [CAF_SID_W-1:0] rx_std_identifier_in,
   input wire logic [CAF_EID_W-1:0] rx_ext_identifier_in,
   input wire logic rx_ide_in,
   input wire logic rx_rtr_in,
   input wire logic rx_fdf_in,
   input wire logic rx_reserved_bit_in,
   input wire logic [3:0] rx_dlc_in,
   input wire logic [CAF_DATA_W-1:0] rx_data_in,
   // results
   output logic busy_out,
   output logic done_out,
   output logic store_out,
   output logic [CAF_IDX_W-1:0] store_fifo_out,
   output logic [CAF_IDX_W-1:0] matched_filter_index_out,
   output logic discard_out,
   output logic [NUM_FIFOS-1:0] rx_fifo_flag_out,
   output logic [NUM_FIFOS-1:0] rx_overflow_flag_out,
   output logic [NUM_FIFOS-1:0] transmit_request_out,
   output logic [NUM_FILTERS-1:0] filter_enable_out
);
   initial begin
      if (NUM_FILTERS != CAF_NUM_FILTERS || NUM_FIFOS != CAF_NUM_FIFOS) begin
         $error("caf_filter: filter and fifo counts must match 5-bit indices");
      end
   end

   // ****************************************************************
   // reset release
   // ****************************************************************
   logic rst_meta_n;
   logic rst_n;

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // ****************************************************************
   // filter table
   // ****************************************************************
   logic [CAF_ENTRY_W-1:0] rd_entry;
   logic [CAF_IDX_W-1:0] scan_idx;
   logic [NUM_FILTERS-1:0] enable_q;

   caf_filter_mem #(
      .WIDTH(CAF_ENTRY_W),
      .DEPTH(NUM_FILTERS),
      .AW(CAF_IDX_W)
   ) u_mem (
      .clk_in(mclk_in),
      .wr_en_in(cfg_wr_in),
      .wr_addr_in(cfg_idx_in),
      .wr_data_in({cfg_filter_buffer_pointer_in, cfg_mask_object_in, cfg_filter_object_in}),
      .rd_addr_in(scan_idx),
      .rd_data_out(rd_entry)
   );

   // enables live in flops so every filter is off after reset
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         enable_q <= CAF_ENABLE_RST;
      end else if (cfg_wr_in) begin
         enable_q[cfg_idx_in] <= cfg_filter_enable_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         filter_enable_out <= CAF_ENABLE_RST;
      end else begin
         filter_enable_out <= enable_q;
      end
   end

   // ****************************************************************
   // latched frame
   // ****************************************************************
   logic [CAF_SID_W-1:0] f_sid;
   logic [CAF_EID_W-1:0] f_eid;
   logic f_ide;
   logic f_rtr;
   logic f_fdf;
   logic f_rsv;
   logic [3:0] f_dlc;
   logic [CAF_DATA_W-1:0] f_data;
   logic f_err;
   caf_state_t state;

   // header is frozen so the whole scan sees one frame
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         f_sid <= '0;
         f_eid <= '0;
         f_ide <= 1'b0;
         f_rtr <= 1'b0;
         f_fdf <= 1'b0;
         f_rsv <= 1'b0;
         f_dlc <= 4'h0;
         f_data <= '0;
      end else if (state == CAF_ST_IDLE && frame_ready_in) begin
         f_sid <= rx_std_identifier_in;
         f_eid <= rx_ext_identifier_in;
         f_ide <= rx_ide_in;
         f_rtr <= rx_rtr_in;
         f_fdf <= rx_fdf_in;
         f_rsv <= rx_reserved_bit_in;
         f_dlc <= rx_dlc_in;
         f_data <= rx_data_in;
      end
   end

   // errors may still show up during the scan, so they accumulate
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         f_err <= 1'b0;
      end else if (state == CAF_ST_IDLE) begin
         f_err <= frame_ready_in && rx_error_in;
      end else if (rx_error_in) begin
         f_err <= 1'b1;
      end
   end

   // ****************************************************************
   // match and decision
   // ****************************************************************
   logic hit;
   logic ovf_done;
   logic [CAF_IDX_W-1:0] bp;
   logic dec_finish;
   logic dec_store;
   logic dec_ovf;
   logic dec_transmit_request;
   logic [NUM_FIFOS-1:0] bp_onehot;

   caf_match u_match (
      .filt_in(rd_entry[0 +: CAF_OBJ_W]),
      .mask_in(rd_entry[CAF_ENT_MASK_LSB +: CAF_OBJ_W]),
      .data_compare_count_in(data_compare_count_in),
      .twelve_bit_id_enable_in(twelve_bit_id_enable_in),
      .rx_std_identifier_in(f_sid),
      .rx_ext_identifier_in(f_eid),
      .rx_ide_in(f_ide),
      .rx_fdf_in(f_fdf),
      .rx_reserved_bit_in(f_rsv),
      .rx_dlc_in(f_dlc),
      .rx_data_in(f_data),
      .hit_out(hit)
   );

   assign bp = rd_entry[CAF_ENT_BP_LSB +: CAF_IDX_W];
   assign bp_onehot = {{(NUM_FIFOS-1){1'b0}}, 1'b1} << bp;

   always_comb begin
      dec_finish = 1'b0;
      dec_store = 1'b0;
      dec_ovf = 1'b0;
      dec_transmit_request = 1'b0;
      if (enable_q[scan_idx] && hit) begin
         if (fifo_is_transmit_in[bp]) begin
            dec_finish = 1'b1;
            if (f_rtr && remote_response_enable_in[bp]) begin
               dec_transmit_request = 1'b1;
               dec_ovf = fifo_empty_in[bp];
            end
            // any other frame aimed at a transmit fifo is dropped
         end else if (fifo_full_in[bp]) begin
            dec_ovf = !ovf_done;
         end else begin
            dec_finish = 1'b1;
            dec_store = !f_err;
         end
      end
      if (scan_idx == CAF_LAST_FILTER) begin
         dec_finish = 1'b1;
      end
   end

   // ****************************************************************
   // scan sequencer
   // ****************************************************************
   // two cycles per filter because the table read is registered
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= CAF_ST_IDLE;
         scan_idx <= '0;
      end else begin
         unique case (state)
            CAF_ST_IDLE: begin
               if (frame_ready_in) begin
                  scan_idx <= '0;
                  state <= CAF_ST_FETCH;
               end
            end
            CAF_ST_FETCH: begin
               state <= CAF_ST_EVAL;
            end
            CAF_ST_EVAL: begin
               if (dec_finish) begin
                  state <= CAF_ST_IDLE;
               end else begin
                  scan_idx <= scan_idx + 5'h01;
                  state <= CAF_ST_FETCH;
               end
            end
            default: begin
               state <= CAF_ST_IDLE;
            end
         endcase
      end
   end

   // only the first full hit of a frame reports overflow
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         ovf_done <= 1'b0;
      end else if (state == CAF_ST_IDLE) begin
         ovf_done <= 1'b0;
      end else if (state == CAF_ST_EVAL && dec_ovf) begin
         ovf_done <= 1'b1;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   logic eval;
   assign eval = (state == CAF_ST_EVAL);

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
         discard_out <= 1'b0;
      end else begin
         busy_out <= (state == CAF_ST_IDLE) ? frame_ready_in : !(eval && dec_finish);
         done_out <= eval && dec_finish;
         discard_out <= eval && dec_finish && !dec_store;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         store_out <= 1'b0;
         store_fifo_out <= '0;
         matched_filter_index_out <= '0;
         rx_fifo_flag_out <= '0;
      end else begin
         store_out <= eval && dec_store;
         rx_fifo_flag_out <= (eval && dec_store) ? bp_onehot : '0;
         if (eval && dec_store) begin
            store_fifo_out <= bp;
            matched_filter_index_out <= scan_idx;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_overflow_flag_out <= '0;
         transmit_request_out <= '0;
      end else begin
         rx_overflow_flag_out <= (eval && dec_ovf) ? bp_onehot : '0;
         transmit_request_out <= (eval && dec_transmit_request) ? bp_onehot : '0;
      end
   end
endmodule

/* File: caf_pkg.sv */
// acceptance filter constants: widths, filter word layout, state encoding
// assumes one controller clock and a frame-assembly stage that feeds it
//
// Behaviour
// - start only after arbitration field plus three bytes
// - scan filters upward from filter 0
// - error-free hit: store, stop, set receive flag
// - remote request hit sets transmit request bit
// - hit on full fifo: overflow, keep scanning
// - all full: overflow only highest-priority hit
// - remote request, transmit fifo empty: overflow
// - no hit at all discards frame
// - hit on transmit fifo without response: discard
// - type mask clear accepts both frame types
// - type mask set: extended bit selects type
// - mask bit zero excludes identifier bit
// - standard filters compare payload through extended field
// - compare count zero disables payload compare
// - payload byte0 bit7 maps to extended bit0
// - count above eighteen compares eighteen bits
// - length code two stops after bit sixteen
// - length code one stops after bit eight
// - length code zero: identifier decides alone
// - twelve-bit mode uses reserved bit as lsb
// - twelve-bit mode only for fd base frames
// - thirty-two filters, each filter plus mask
// - stored frame carries five-bit matched filter index
package caf_pkg;
   localparam int CAF_NUM_FILTERS = 32;
   localparam int CAF_NUM_FIFOS = 32;
   localparam int CAF_IDX_W = 5;
   localparam int CAF_SID_W = 11;
   localparam int CAF_EID_W = 18;
   localparam int CAF_DATA_W = 24;
   localparam int CAF_MAX_DATA_BITS = 18;
   // filter and mask objects share one layout
   localparam int CAF_OBJ_SID_LSB = 0;
   localparam int CAF_OBJ_EID_LSB = 11;
   localparam int CAF_OBJ_ID12_POS = 29;
   localparam int CAF_OBJ_TYPE_POS = 30;
   localparam int CAF_OBJ_W = 31;
   // stored entry: {buffer pointer, mask object, filter object}
   localparam int CAF_ENTRY_W = 2 * CAF_OBJ_W + CAF_IDX_W;
   localparam int CAF_ENT_MASK_LSB = CAF_OBJ_W;
   localparam int CAF_ENT_BP_LSB = 2 * CAF_OBJ_W;
   localparam logic [CAF_NUM_FILTERS-1:0] CAF_ENABLE_RST = 32'h0000_0000;
   localparam logic [4:0] CAF_LAST_FILTER = 5'h1F;
   localparam logic [4:0] CAF_DLC_LIMIT_8 = 5'h08;
   localparam logic [4:0] CAF_DLC_LIMIT_16 = 5'h10;
   typedef enum logic [1:0] {
      CAF_ST_IDLE,
      CAF_ST_FETCH,
      CAF_ST_EVAL
   } caf_state_t;
endpackage

/* File: caf_match.sv */
// compares one filter and mask object against the latched frame header
// assumes all inputs are stable for the cycle the hit is used
`timescale 1ns/1ps
module caf_match
   import caf_pkg::*;
(
   // filter and mask objects
   input wire logic [CAF_OBJ_W-1:0] filt_in,
   input wire logic [CAF_OBJ_W-1:0] mask_in,
   // global settings
   input wire logic [4:0] data_compare_count_in,
   input wire logic twelve_bit_id_enable_in,
   // frame
   input wire logic [CAF_SID_W-1:0] rx_std_identifier_in,
   input wire logic [CAF_EID_W-1:0] rx_ext_identifier_in,
   input wire logic rx_ide_in,
   input wire logic rx_fdf_in,
   input wire logic rx_reserved_bit_in,
   input wire logic [3:0] rx_dlc_in,
   input wire logic [CAF_DATA_W-1:0] rx_data_in,
   // result
   output logic hit_out
);
   logic [CAF_SID_W-1:0] f_sid;
   logic [CAF_SID_W-1:0] m_sid;
   logic [CAF_EID_W-1:0] f_eid;
   logic [CAF_EID_W-1:0] m_eid;
   logic [CAF_EID_W-1:0] pay_bits;
   logic [4:0] ncmp;
   logic type_ok;
   logic sid_ok;
   logic id12_ok;
   logic eid_ok;
   logic pay_ok;

   assign f_sid = filt_in[CAF_OBJ_SID_LSB +: CAF_SID_W];
   assign m_sid = mask_in[CAF_OBJ_SID_LSB +: CAF_SID_W];
   assign f_eid = filt_in[CAF_OBJ_EID_LSB +: CAF_EID_W];
   assign m_eid = mask_in[CAF_OBJ_EID_LSB +: CAF_EID_W];

   // payload bit k is byte k/8, bit 7-k%8, msb first
   genvar k;
   generate
      for (k = 0; k < CAF_EID_W; k++) begin : g_pay
         assign pay_bits[k] = rx_data_in[(k / 8) * 8 + 7 - (k % 8)];
      end
   endgenerate

   // effective compare length after count and length code clamps
   always_comb begin
      if (data_compare_count_in > 5'(CAF_MAX_DATA_BITS)) begin
         ncmp = 5'(CAF_MAX_DATA_BITS);
      end else begin
         ncmp = data_compare_count_in;
      end
      if (rx_dlc_in == 4'h0) begin
         ncmp = 5'h00;
      end else if (rx_dlc_in == 4'h1 && ncmp > CAF_DLC_LIMIT_8) begin
         ncmp = CAF_DLC_LIMIT_8;
      end else if (rx_dlc_in == 4'h2 && ncmp > CAF_DLC_LIMIT_16) begin
         ncmp = CAF_DLC_LIMIT_16;
      end
   end

   always_comb begin
      pay_ok = 1'b1;
      for (int i = 0; i < CAF_EID_W; i++) begin
         if (5'(i) < ncmp && m_eid[i] && (pay_bits[i] != f_eid[i])) begin
            pay_ok = 1'b0;
         end
      end
   end

   // type check: mask clear takes both kinds
   assign type_ok = !mask_in[CAF_OBJ_TYPE_POS] || (rx_ide_in == filt_in[CAF_OBJ_TYPE_POS]);
   assign sid_ok = ((rx_std_identifier_in ^ f_sid) & m_sid) == '0;
   assign eid_ok = ((rx_ext_identifier_in ^ f_eid) & m_eid) == '0;
   // reserved bit acts as the twelfth id bit for fd base frames only
   assign id12_ok = !(twelve_bit_id_enable_in && rx_fdf_in && !rx_ide_in)
      || !mask_in[CAF_OBJ_ID12_POS]
      || (rx_reserved_bit_in == filt_in[CAF_OBJ_ID12_POS]);

   assign hit_out = type_ok && sid_ok && (rx_ide_in ? eid_ok : (id12_ok && pay_ok));
endmodule

/* File: caf_filter_mem.sv */
// storage for the filter, mask and buffer pointer of every filter
// assumes one writer port from software and one scanner read port
`timescale 1ns/1ps
module caf_filter_mem #(
   parameter int WIDTH = 67,
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   // clock
   input wire logic clk_in,
   // write side
   input wire logic wr_en_in,
   input wire logic [AW-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   // read side
   input wire logic [AW-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   initial begin
      if (DEPTH > (1 << AW) || DEPTH < 1) begin
         $error("caf_filter_mem: depth does not fit address width");
      end
   end

   logic [WIDTH-1:0] mem [DEPTH];

   // no reset: contents are only trusted once their enable is set
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      rd_data_out <= mem[rd_addr_in];
   end
endmodule

/* File: caf_filter_properties.sv */
// checker for the acceptance filter: port timing and flag relations
// assumes it is bound into caf_filter and sees only its ports
`timescale 1ns/1ps
module caf_filter_checker
   import caf_pkg::*;
#(
   parameter int NUM_FILTERS = CAF_NUM_FILTERS,
   parameter int NUM_FIFOS = CAF_NUM_FIFOS
) (
   // clock, reset and requests
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic cfg_wr_in,
   input wire logic [CAF_IDX_W-1:0] cfg_idx_in,
   input wire logic cfg_filter_enable_in,
   input wire logic frame_ready_in,
   // results
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic store_out,
   input wire logic [CAF_IDX_W-1:0] store_fifo_out,
   input wire logic [CAF_IDX_W-1:0] matched_filter_index_out,
   input wire logic discard_out,
   input wire logic [NUM_FIFOS-1:0] rx_fifo_flag_out,
   input wire logic [NUM_FIFOS-1:0] rx_overflow_flag_out,
   input wire logic [NUM_FIFOS-1:0] transmit_request_out,
   input wire logic [NUM_FILTERS-1:0] filter_enable_out
);
   // ****
   // properties
   // ****
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);
   sequence s_take;
      frame_ready_in && !busy_out;
   endsequence
   sequence s_cfg;
      cfg_wr_in ##2 1'b1;
   endsequence
   property p_take;
      s_take |=> busy_out;
   endproperty
   a_take: assert property (p_take) else $error("no scan after frame");
   // longest scan walks all filters, two cycles each
   property p_scan_len;
      s_take |-> ##[2:70] done_out;
   endproperty
   a_scan_len: assert property (p_scan_len) else $error("scan too long");
   property p_store_flag;
      store_out |-> $onehot(rx_fifo_flag_out) && rx_fifo_flag_out[store_fifo_out];
   endproperty
   a_store_flag: assert property (p_store_flag) else $error("bad rx flag");
   property p_one_end;
      done_out |-> store_out ^ discard_out;
   endproperty
   a_one_end: assert property (p_one_end) else $error("bad frame end");
   property p_ovf_once;
      $onehot0(rx_overflow_flag_out);
   endproperty
   a_ovf_once: assert property (p_ovf_once) else $error("many overflows");
   property p_ovf_scan;
      |rx_overflow_flag_out |-> busy_out || done_out;
   endproperty
   a_ovf_scan: assert property (p_ovf_scan) else $error("overflow off scan");
   property p_treq;
      |transmit_request_out |-> $onehot(transmit_request_out) ##[0:1] discard_out;
   endproperty
   a_treq: assert property (p_treq) else $error("bad transmit request");
   property p_enable;
      s_cfg |-> filter_enable_out[$past(cfg_idx_in, 2)] == $past(cfg_filter_enable_in, 2);
   endproperty
   a_enable: assert property (p_enable) else $error("enable not taken");
   property p_idx_held;
      $changed(matched_filter_index_out) |-> store_out;
   endproperty
   a_idx_held: assert property (p_idx_held) else $error("index moved");
endmodule

bind caf_filter caf_filter_checker #(
   .NUM_FILTERS(NUM_FILTERS),
   .NUM_FIFOS(NUM_FIFOS)
) i_chk (
   .mclk_in, .rstn_in, .cfg_wr_in, .cfg_idx_in, .cfg_filter_enable_in, .frame_ready_in,
   .busy_out, .done_out, .store_out, .store_fifo_out, .matched_filter_index_out,
   .discard_out, .rx_fifo_flag_out, .rx_overflow_flag_out, .transmit_request_out,
   .filter_enable_out
);

/* File: caf_node_model.sv */
// node model: presents received frames as the assembly stage would
// assumes frames are requested only while the filter is idle
`timescale 1ns/1ps
module caf_node_model (
   // clock and request
   input wire logic mclk_in,
   input wire logic send_in,
   input wire logic err_in,
   // frame {sid, eid, ide, rtr, fdf, rrs, dlc, data}
   input wire logic [60:0] frame_in,
   // toward the filter
   output logic frame_ready_out,
   output logic rx_error_out,
   output logic [60:0] rx_out
);
   logic [60:0] last;
   initial begin
      frame_ready_out = 1'b0;
      rx_error_out = 1'b0;
      rx_out = 61'h0;
      last = 61'h0;
   end
   // ****
   // presentation
   // ****
   // header and three data bytes go out together in the strobe cycle
   always @(posedge mclk_in) begin
      frame_ready_out <= send_in;
      // error flag only stands with its own frame, or it would taint the next ones
      rx_error_out <= send_in && err_in;
      if (send_in) begin
         rx_out <= frame_in;
         last <= frame_in;
      end else begin
         // released: never let a stale frame look valid
         rx_out <= ~last;
      end
   end
endmodule

/* File: caf_filter_tb.sv */
// bench for caf_filter: fixed filter table, frames from the node model
// assumes caf_node_model on the frame inputs and the bound checker
`timescale 1ns/1ps
module caf_filter_tb;
   localparam logic [23:0] PAY = 24'h80_5A3C;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic cfg_wr = 1'b0;
   logic cfg_en = 1'b0;
   logic t12 = 1'b0;
   logic send = 1'b0;
   logic err = 1'b0;
   logic [4:0] cfg_idx = 5'h00;
   logic [4:0] cfg_bp = 5'h00;
   logic [4:0] dcc = 5'h00;
   logic [30:0] cfg_fo = 31'h0;
   logic [30:0] cfg_mo = 31'h0;
   logic [60:0] frm = 61'h0;
   logic [31:0] f_tx = 32'h0000_0180;
   logic [31:0] f_rre = 32'h0000_0080;
   logic [31:0] f_full = 32'h0000_0060;
   logic [31:0] f_empty = 32'h0000_0080;
   logic [60:0] rxv;
   logic rdy, rxerr, busy, done, store, disc;
   logic [4:0] sf, mi;
   logic [31:0] rxf, ovf, treq, fen;
   logic [107:0] res;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;

   caf_filter i_dut (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .cfg_wr_in(cfg_wr), .cfg_idx_in(cfg_idx),
      .cfg_filter_object_in(cfg_fo), .cfg_mask_object_in(cfg_mo),
      .cfg_filter_buffer_pointer_in(cfg_bp), .cfg_filter_enable_in(cfg_en),
      .data_compare_count_in(dcc), .twelve_bit_id_enable_in(t12),
      .fifo_is_transmit_in(f_tx), .remote_response_enable_in(f_rre),
      .fifo_full_in(f_full), .fifo_empty_in(f_empty),
      .frame_ready_in(rdy), .rx_error_in(rxerr), .rx_std_identifier_in(rxv[60:50]),
      .rx_ext_identifier_in(rxv[49:32]), .rx_ide_in(rxv[31]), .rx_rtr_in(rxv[30]),
      .rx_fdf_in(rxv[29]), .rx_reserved_bit_in(rxv[28]), .rx_dlc_in(rxv[27:24]),
      .rx_data_in(rxv[23:0]), .busy_out(busy), .done_out(done), .store_out(store),
      .store_fifo_out(sf), .matched_filter_index_out(mi), .discard_out(disc),
      .rx_fifo_flag_out(rxf), .rx_overflow_flag_out(ovf), .transmit_request_out(treq),
      .filter_enable_out(fen)
   );
   caf_node_model i_node (
      .mclk_in(mclk_in), .send_in(send), .err_in(err), .frame_in(frm),
      .frame_ready_out(rdy), .rx_error_out(rxerr), .rx_out(rxv)
   );

   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         close_out();
      end
   end

   // ****
   // helpers
   // ****
   task automatic chk(input logic [107:0] got, input logic [107:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors=%0d checks=%0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // payload byte 0 bit 7 lands on extended bit 0, byte 2 bit 6 on bit 17
   function automatic logic [17:0] pm(input logic [23:0] d);
      logic [17:0] e;
      for (int k = 0; k < 8; k++) begin
         e[k] = d[7-k];
         e[k+8] = d[15-k];
      end
      e[16] = d[23];
      e[17] = d[22];
      return e;
   endfunction
   function automatic logic [107:0] ex(input logic st, input logic [4:0] f = 5'h00,
      input logic [4:0] i = 5'h00, input logic [31:0] of = 32'h0, input logic [31:0] tq = 32'h0);
      return {st, !st, st ? f : 5'h00, st ? i : 5'h00, st ? 32'h1 << f : 32'h0, of, tq};
   endfunction
   task automatic wr(input logic [4:0] i, input logic [10:0] s, input logic [4:0] bp,
      input logic [10:0] ms = 11'h7FF, input logic mt = 1'b1, input logic xs = 1'b0,
      input logic [17:0] e = 18'h0, input logic [17:0] em = 18'h0, input logic b12 = 1'b0,
      input logic en = 1'b1);
      @(posedge mclk_in);
      cfg_wr <= 1'b1;
      cfg_idx <= i;
      cfg_fo <= {xs, b12, e, s};
      cfg_mo <= {mt, b12, em, ms};
      cfg_bp <= bp;
      cfg_en <= en;
      @(posedge mclk_in);
      cfg_wr <= 1'b0;
      @(posedge mclk_in);
   endtask
   // pulses are or-ed over the whole scan, so a stray one anywhere shows
   task automatic fr(input logic [10:0] s, input logic ide = 1'b0, input logic rtr = 1'b0,
      input logic fdf = 1'b0, input logic rrs = 1'b0, input logic [3:0] dlc = 4'h8,
      input logic [23:0] d = 24'h0, input logic e = 1'b0);
      int k;
      k = 0;
      res = 108'h0;
      @(posedge mclk_in);
      frm <= {s, 18'h2_AAAA, ide, rtr, fdf, rrs, dlc, d};
      err <= e;
      send <= 1'b1;
      @(posedge mclk_in);
      send <= 1'b0;
      do begin
         @(posedge mclk_in);
         #1;
         res = res | {store, disc, store ? sf : 5'h00, store ? mi : 5'h00, rxf, ovf, treq};
         k++;
      end while (done !== 1'b1 && k < 80);
   endtask

   // ****
   // scenarios
   // ****
   task automatic t_type();
      fr(11'h100);
      chk(res, ex(1'b1, 5'h03, 5'h00));
      fr(11'h100, .ide(1'b1));
      chk(res, ex(1'b1, 5'h09, 5'h01));
      fr(11'h180);
      chk(res, ex(1'b0));
      fr(11'h180, .ide(1'b1));
      chk(res, ex(1'b1, 5'h03, 5'h0A));
   endtask
   task automatic t_mask();
      fr(11'h203);
      chk(res, ex(1'b1, 5'h03, 5'h02));
      fr(11'h204);
      chk(res, ex(1'b0));
   endtask
   task automatic t_fault();
      fr(11'h300);
      chk(res, ex(1'b1, 5'h03, 5'h05, 32'h20));
      fr(11'h380);
      chk(res, ex(1'b0, .of(32'h20)));
      fr(11'h400, .rtr(1'b1));
      chk(res, ex(1'b0, .of(32'h80), .tq(32'h80)));
      fr(11'h500);
      chk(res, ex(1'b0));
      fr(11'h100, .e(1'b1));
      chk(res, ex(1'b0));
      fr(11'h500, .rtr(1'b1));
      chk(res, ex(1'b0));
      @(posedge mclk_in);
      f_empty <= 32'h0000_0000;
      f_rre <= 32'h0000_0180;
      f_full <= 32'h0000_0068;
      fr(11'h400, .rtr(1'b1));
      chk(res, ex(1'b0, .tq(32'h80)));
      fr(11'h500, .rtr(1'b1));
      chk(res, ex(1'b0, .tq(32'h100)));
      fr(11'h100);
      chk(res, ex(1'b1, 5'h09, 5'h01, 32'h08));
      @(posedge mclk_in);
      f_tx <= 32'h0000_0188;
      fr(11'h100);
      chk(res, ex(1'b0));
      @(posedge mclk_in);
      f_tx <= 32'h0000_0180;
      f_full <= 32'h0000_0060;
   endtask
   task automatic pay(input logic [4:0] n, input logic [3:0] dlc, input int b, input logic h);
      @(posedge mclk_in);
      dcc <= n;
      fr(11'h600, .dlc(dlc), .d(PAY ^ (24'h1 << b)));
      chk(res, ex(h, 5'h03, 5'h08));
   endtask
   task automatic t_pay();
      pay(5'h00, 4'h8, 0, 1'b1);
      pay(5'h01, 4'h8, 7, 1'b0);
      pay(5'h01, 4'h8, 6, 1'b1);
      pay(5'h11, 4'h8, 23, 1'b0);
      pay(5'h12, 4'h8, 22, 1'b0);
      pay(5'h1F, 4'h8, 21, 1'b1);
      pay(5'h11, 4'h2, 23, 1'b1);
      pay(5'h09, 4'h1, 15, 1'b1);
      pay(5'h08, 4'h1, 0, 1'b0);
      pay(5'h05, 4'h0, 7, 1'b1);
   endtask
   task automatic tw(input logic t, input logic fdf, input logic rrs, input logic h);
      @(posedge mclk_in);
      t12 <= t;
      dcc <= 5'h00;
      fr(11'h700, .fdf(fdf), .rrs(rrs));
      chk(res, ex(h, 5'h03, 5'h09));
   endtask
   task automatic t_twelve();
      tw(1'b1, 1'b1, 1'b1, 1'b1);
      tw(1'b1, 1'b1, 1'b0, 1'b0);
      tw(1'b1, 1'b0, 1'b0, 1'b1);
      tw(1'b0, 1'b1, 1'b0, 1'b1);
   endtask

   initial begin
      repeat (8) @(posedge mclk_in);
      rstn_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
      chk(108'(fen), 108'h0);
      // each entry written whole in one cycle, enable together with it
      wr(5'h00, 11'h100, 5'h03);
      wr(5'h01, 11'h100, 5'h09, .mt(1'b0));
      wr(5'h02, 11'h200, 5'h03, .ms(11'h7FC));
      wr(5'h03, 11'h300, 5'h05);
      wr(5'h04, 11'h300, 5'h06);
      wr(5'h05, 11'h300, 5'h03);
      wr(5'h06, 11'h400, 5'h07);
      wr(5'h07, 11'h500, 5'h08);
      wr(5'h08, 11'h600, 5'h03, .e(pm(PAY)), .em(18'h3_FFFF));
      wr(5'h09, 11'h700, 5'h03, .b12(1'b1));
      wr(5'h0A, 11'h180, 5'h03, .xs(1'b1));
      wr(5'h0B, 11'h380, 5'h05);
      wr(5'h0C, 11'h380, 5'h06);
      wr(5'h1F, 11'h000, 5'h03, .ms(11'h000), .mt(1'b0), .en(1'b0));
      repeat (2) @(posedge mclk_in);
      chk(108'(fen), 108'h1FFF);
      t_type();
      t_mask();
      t_fault();
      t_pay();
      t_twelve();
      close_out();
   end
endmodule
